// >>> spcs_defines.svh
`ifndef SPCS_DEFINES_SVH
`define SPCS_DEFINES_SVH

// ************************************************************
// Field positions
// ************************************************************
`define SPCS_GCR_CTRL_BIT    0
`define SPCS_FMT_PHASE_BIT   16
`define SPCS_FMT_POL_BIT     17
`define SPCS_FMT_PS_MSB      15
`define SPCS_FMT_PS_LSB      8
`define SPCS_DLY_SETUP_MSB   31
`define SPCS_DLY_SETUP_LSB   24
`define SPCS_DLY_REL_MSB     23
`define SPCS_DLY_REL_LSB     16

// ************************************************************
// Sizes and timing counts, in peripheral clock cycles
// ************************************************************
`define SPCS_WORD_W          16
`define SPCS_FIFO_DEPTH      8
`define SPCS_CNT_W           10
`define SPCS_EDGES           6'h20
`define SPCS_PS0_PERIOD      10'h002
`define SPCS_SETUP_EXTRA     10'h002
`define SPCS_HOLD_EXTRA      10'h001
`define SPCS_REL_EXTRA       10'h001

`endif

// >>> spcs_pkg.sv
package spcs_pkg;

   typedef enum logic [2:0] {
      SPCS_IDLE  = 3'h0,
      SPCS_SETUP = 3'h1,
      SPCS_DATA  = 3'h3,
      SPCS_REL   = 3'h2
   } spcs_state_type;

endpackage

// >>> spcs_fifo.sv
`timescale 1ns/1ns

module spcs_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // Filling side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Draining side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   localparam int AW = $clog2(D);

   logic [W-1:0]  mem_r [D];
   logic [W-1:0]  mem_nxt [D];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]   cnt_r, cnt_nxt;
   logic          nfull_r, nfull_nxt, nempty_r, nempty_nxt;
   logic          push, pop;

   // ************************************************************
   // Next state
   // ************************************************************
   // Full and empty are registered so the top sees flop outputs
   always_comb begin
      push       = in_valid && nfull_r;
      pop        = out_ready && nempty_r;
      mem_nxt    = mem_r;
      wp_nxt     = wp_r;
      rp_nxt     = rp_r;
      if (push) begin
         mem_nxt[wp_r] = in_data;
         wp_nxt        = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
         rp_nxt = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_nxt    = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
      nfull_nxt  = (cnt_nxt != (AW + 1)'(D));
      nempty_nxt = (cnt_nxt != '0);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wp_r     <= '0;
         rp_r     <= '0;
         cnt_r    <= '0;
         nfull_r  <= 1'b1;
         nempty_r <= 1'b0;
      end else begin
         wp_r     <= wp_nxt;
         rp_r     <= rp_nxt;
         cnt_r    <= cnt_nxt;
         nfull_r  <= nfull_nxt;
         nempty_r <= nempty_nxt;
      end
      mem_r <= mem_nxt;
   end

   assign in_ready  = nfull_r;
   assign out_valid = nempty_r;
   assign out_data  = mem_r[rp_r];

endmodule

// >>> spcs_ctrl.sv
`timescale 1ns/1ns
`include "spcs_defines.svh"

// Overview of operation
// [RQ1] Controller bit drives clock, data; bit16 selects phase
// [RQ2] Clock period prescale+1 cycles, two for zero
// [RQ3] Polarity bit17 sets idle level, active edge
// [RQ4] Setup and release counts from delay register
// [RQ5] Phase one: first edge after half+setup+2(+3); code adds 1, only with pol and cs_keep_asserted_option set
// [RQ6] Phase one: CS releases release+1 after last
// [RQ7] Phase zero: CS releases half+release+1 after last
module spcs_ctrl (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    nrst,
   // Configuration words and options
   input  wire logic [31:0]             global_control_reg,
   input  wire logic [31:0]             frame_format_reg,
   input  wire logic [31:0]             cs_delay_reg,
   input  wire logic                    cs_keep_asserted_option,
   // Transmit words into the FIFO
   input  wire logic                    tx_valid,
   output logic                         tx_ready,
   input  wire logic [`SPCS_WORD_W-1:0] tx_data,
   // Received words
   output logic                         rx_valid,
   output logic [`SPCS_WORD_W-1:0]      rx_data,
   output logic                         busy,
   // Serial pins
   output logic                         serial_clock_pin,
   output logic                         serial_clock_oe,
   output logic                         controller_out_data_pin,
   output logic                         controller_out_data_oe,
   input  wire logic                    controller_in_data_pin,
   output logic                         cs_n
);

   spcs_pkg::spcs_state_type st_r, st_nxt;
   logic [`SPCS_CNT_W-1:0]   cnt_r, cnt_nxt;
   logic [5:0]               edge_r, edge_nxt;
   logic [`SPCS_WORD_W-1:0]  tsh_r, tsh_nxt, rsh_r, rsh_nxt;
   logic [`SPCS_WORD_W-1:0]  rxd_r, rxd_nxt;
   logic                     sck_r, sck_nxt, mosi_r, mosi_nxt;
   logic                     csn_r, csn_nxt, rxv_r, rxv_nxt;
   logic                     oe_r, busy_r;
   logic                     f_valid, f_pop;
   logic [`SPCS_WORD_W-1:0]  f_data;
   logic                     en, pha, pol;
   logic [7:0]               ps, c2t, t2c;
   logic [`SPCS_CNT_W-1:0]   period, half_lo, half_hi;
   logic [`SPCS_CNT_W-1:0]   setup_len, rel_len, wait_len;
   logic                     lead;

   // ************************************************************
   // Transmit FIFO
   // ************************************************************
   spcs_fifo #(
      .W (`SPCS_WORD_W),
      .D (`SPCS_FIFO_DEPTH)
   ) spcs_fifo_inst (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   (tx_data),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   // ************************************************************
   // Timing figures
   // ************************************************************
   always_comb begin
      en  = global_control_reg[`SPCS_GCR_CTRL_BIT];
      pha = frame_format_reg[`SPCS_FMT_PHASE_BIT];
      pol = frame_format_reg[`SPCS_FMT_POL_BIT];
      ps  = frame_format_reg[`SPCS_FMT_PS_MSB:`SPCS_FMT_PS_LSB];
      // [RQ4] delay register fields
      c2t = cs_delay_reg[`SPCS_DLY_SETUP_MSB:`SPCS_DLY_SETUP_LSB];
      t2c = cs_delay_reg[`SPCS_DLY_REL_MSB:`SPCS_DLY_REL_LSB];
      // [RQ2] prescale to period
      period  = (ps == 8'h00) ? `SPCS_PS0_PERIOD
                              : `SPCS_CNT_W'(ps) + 10'h001;
      half_lo = period >> 1;
      half_hi = period - half_lo;
      // [RQ5] setup from CS to first edge
      setup_len = `SPCS_CNT_W'(c2t) + `SPCS_SETUP_EXTRA;
      if (pha) begin
         setup_len = setup_len + half_lo;
         if (pol && cs_keep_asserted_option) begin
            setup_len = setup_len + `SPCS_HOLD_EXTRA;
         end
      end
      // [RQ6] [RQ7] last edge to CS release
      rel_len = `SPCS_CNT_W'(t2c) + `SPCS_REL_EXTRA;
      if (!pha) begin
         rel_len = rel_len + half_lo;
      end
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   always_comb begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      edge_nxt = edge_r;
      tsh_nxt  = tsh_r;
      rsh_nxt  = rsh_r;
      rxd_nxt  = rxd_r;
      sck_nxt  = sck_r;
      mosi_nxt = mosi_r;
      csn_nxt  = csn_r;
      rxv_nxt  = 1'b0;
      f_pop    = 1'b0;
      lead     = 1'b0;
      wait_len = half_lo;
      case (st_r)
         spcs_pkg::SPCS_IDLE: begin
            // [RQ3] clock rests at the polarity level
            sck_nxt  = pol;
            edge_nxt = 6'h00;
            if (en && f_valid) begin
               f_pop    = 1'b1;
               tsh_nxt  = f_data;
               mosi_nxt = f_data[`SPCS_WORD_W-1];
               csn_nxt  = 1'b0;
               cnt_nxt  = setup_len - 10'h001;
               st_nxt   = spcs_pkg::SPCS_SETUP;
            end
         end
         spcs_pkg::SPCS_SETUP, spcs_pkg::SPCS_DATA: begin
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - 10'h001;
            end else begin
               sck_nxt  = ~sck_r;
               edge_nxt = edge_r + 6'h01;
               lead     = !edge_r[0];
               // [RQ1] phase picks launch versus capture edge
               if (lead == pha) begin
                  mosi_nxt = tsh_r[`SPCS_WORD_W-1];
                  if (!pha) begin
                     mosi_nxt = tsh_r[`SPCS_WORD_W-2];
                  end
                  tsh_nxt = {tsh_r[`SPCS_WORD_W-2:0], 1'b0};
               end else begin
                  rsh_nxt = {rsh_r[`SPCS_WORD_W-2:0],
                             controller_in_data_pin};
               end
               // Halves alternate so odd periods still sum right
               wait_len = lead ? half_hi : half_lo;
               cnt_nxt  = wait_len - 10'h001;
               st_nxt   = spcs_pkg::SPCS_DATA;
               if (edge_nxt == `SPCS_EDGES) begin
                  cnt_nxt = rel_len - 10'h001;
                  st_nxt  = spcs_pkg::SPCS_REL;
               end
            end
         end
         spcs_pkg::SPCS_REL: begin
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - 10'h001;
            end else begin
               rxv_nxt  = 1'b1;
               rxd_nxt  = rsh_r;
               edge_nxt = 6'h00;
               if (cs_keep_asserted_option && en && f_valid) begin
                  f_pop    = 1'b1;
                  tsh_nxt  = f_data;
                  mosi_nxt = f_data[`SPCS_WORD_W-1];
                  cnt_nxt  = setup_len - 10'h001;
                  st_nxt   = spcs_pkg::SPCS_SETUP;
               end else begin
                  csn_nxt = 1'b1;
                  st_nxt  = spcs_pkg::SPCS_IDLE;
               end
            end
         end
         default: begin
            st_nxt = spcs_pkg::SPCS_IDLE;
         end
      endcase
      // Leaving controller mode aborts the word; no partial result
      if (!en) begin
         st_nxt   = spcs_pkg::SPCS_IDLE;
         csn_nxt  = 1'b1;
         sck_nxt  = pol;
         f_pop    = 1'b0;
         edge_nxt = 6'h00;
         rxv_nxt  = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r   <= spcs_pkg::SPCS_IDLE;
         cnt_r  <= '0;
         edge_r <= 6'h00;
         tsh_r  <= '0;
         rsh_r  <= '0;
         rxd_r  <= '0;
         sck_r  <= 1'b0;
         mosi_r <= 1'b0;
         csn_r  <= 1'b1;
         rxv_r  <= 1'b0;
         oe_r   <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         edge_r <= edge_nxt;
         tsh_r  <= tsh_nxt;
         rsh_r  <= rsh_nxt;
         rxd_r  <= rxd_nxt;
         sck_r  <= sck_nxt;
         mosi_r <= mosi_nxt;
         csn_r  <= csn_nxt;
         rxv_r  <= rxv_nxt;
         // [RQ1] pins driven only as controller
         oe_r   <= en;
         busy_r <= (st_nxt != spcs_pkg::SPCS_IDLE);
      end
   end

   assign serial_clock_pin        = sck_r;
   assign serial_clock_oe         = oe_r;
   assign controller_out_data_pin = mosi_r;
   assign controller_out_data_oe  = oe_r;
   assign cs_n                    = csn_r;
   assign rx_valid                = rxv_r;
   assign rx_data                 = rxd_r;
   assign busy                    = busy_r;

   // ************************************************************
   // Checks
   // ************************************************************
   logic [`SPCS_CNT_W-1:0] su_r, rl_r, gp_r, lh_r;
   always_ff @(posedge clk) begin
      su_r <= (st_r == spcs_pkg::SPCS_SETUP) ? su_r + 10'h001 : '0;
      rl_r <= (st_r == spcs_pkg::SPCS_REL) ? rl_r + 10'h001 : '0;
      gp_r <= (sck_nxt != sck_r) ? '0 : gp_r + 10'h001;
      if (sck_nxt != sck_r) begin
         lh_r <= gp_r;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   drive_enable_a: assert property (nrst |=> //[RQ1]
      (serial_clock_oe == $past(en) &&
       controller_out_data_oe == $past(en)))
      else $error("pin enables do not follow controller bit");
   clock_period_a: assert property ( //[RQ2]
      (sck_r != $past(sck_r) && edge_r >= 6'h03 && $stable(ps))
      |-> ($past(gp_r) + $past(lh_r) + 10'h002 == period))
      else $error("serial clock period wrong");
   idle_level_a: assert property ( //[RQ3]
      (st_r == spcs_pkg::SPCS_IDLE && $past(st_r) ==
       spcs_pkg::SPCS_IDLE && $stable(pol) && $past(nrst))
      |-> sck_r == pol)
      else $error("idle clock level wrong");
   setup_delay_a: assert property ( //[RQ5]
      (st_r == spcs_pkg::SPCS_DATA &&
       $past(st_r) == spcs_pkg::SPCS_SETUP && $stable(cs_delay_reg))
      |-> ($changed(sck_r) && su_r == setup_len))
      else $error("chip select setup delay wrong");
   cs_setup_a: assert property ( //[RQ4]
      $fell(csn_r) |-> !csn_r [*2])
      else $error("chip select dropped during setup");
   release_one_a: assert property ( //[RQ6]
      ($rose(csn_r) && pha && $stable(cs_delay_reg) && en)
      |-> rl_r == `SPCS_CNT_W'(t2c) + `SPCS_REL_EXTRA)
      else $error("phase one release delay wrong");
   release_zero_a: assert property ( //[RQ7]
      ($rose(csn_r) && !pha && $stable(frame_format_reg) && en)
      |-> rl_r == half_lo + `SPCS_CNT_W'(t2c) + `SPCS_REL_EXTRA)
      else $error("phase zero release delay wrong");

   word_phase0_c: cover property ($rose(csn_r) && !pha);
   word_phase1_c: cover property ($rose(csn_r) && pha && pol);
   held_cs_c: cover property (rxv_r && !csn_r);

endmodule

// >>> spcs_peer.sv
`timescale 1ns/1ns

// ************************************************************
// Far-side serial peripheral model
// ************************************************************
module spcs_peer (
   // Serial pins
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic        mosi,
   output logic             miso,
   // Mode and words
   input  wire logic        pha,
   input  wire logic [15:0] reply,
   output logic [15:0]      got
);
   int cnt;

   initial begin
      miso = 1'b0;
      got = 16'h0000;
      cnt = 0;
   end

   // Phase zero shows the first bit as soon as it is selected
   always @(negedge cs_n) begin
      cnt = 0;
      if (!pha) begin
         miso = reply[15];
      end
   end

   // Released line shows the inverse, so a stale bit is never trusted
   always @(posedge cs_n) begin
      miso = ~miso;
   end

   // Capture on one edge kind, launch on the other, both MSB first
   always @(sck) begin
      if (cs_n === 1'b0) begin
         cnt = cnt + 1;
         if ((cnt % 2 == 1) != pha) begin
            got = {got[14:0], mosi};
         end else begin
            // A held select runs on into the next word, so wrap
            miso = reply[15 - (cnt / 2) % 16];
         end
      end
   end
endmodule

// >>> spcs_ctrl_test.sv
`timescale 1ns/1ns

module spcs_ctrl_test;
   // ************************************************************
   // Signals
   // ************************************************************
   logic        clk, nrst, keep, tx_valid, tx_ready, rx_valid, busy;
   logic        sck, sck_oe, mosi, mosi_oe, miso, cs_n;
   logic [31:0] gcr, fmt, dly;
   logic [15:0] tx_data, rx_data, reply, got;
   int          fail_count, n_compared;

   spcs_ctrl spcs_ctrl_inst (
      .clk(clk), .nrst(nrst), .global_control_reg(gcr),
      .frame_format_reg(fmt), .cs_delay_reg(dly),
      .cs_keep_asserted_option(keep), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
      .rx_data(rx_data), .busy(busy), .serial_clock_pin(sck),
      .serial_clock_oe(sck_oe), .controller_out_data_pin(mosi),
      .controller_out_data_oe(mosi_oe),
      .controller_in_data_pin(miso), .cs_n(cs_n));

   spcs_peer spcs_peer_inst (
      .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .pha(fmt[16]), .reply(reply), .got(got));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ************************************************************
   // Compare and report
   // ************************************************************
   task automatic chk_n(input string what, input int exp, input int seen);
      n_compared++;
      if (exp != seen) begin
         fail_count++;
         $display("ERROR %s expected %0d seen %0d", what, exp, seen);
      end
   endtask

   task automatic chk_v(input string what, input logic [15:0] exp,
                        input logic [15:0] seen);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic timeout;
      fail_count++;
      $display("ERROR wait expected done seen limit");
      tally_and_finish;
   endtask

   // ************************************************************
   // Drivers
   // ************************************************************
   task automatic setup(input logic [7:0] ps, input logic pha, pol,
                        input logic [7:0] c2t, t2c, input logic hold);
      @(posedge clk);
      #1;
      fmt = {14'h0000, pol, pha, ps, 8'h00};
      dly = {c2t, t2c, 16'h0000};
      keep = hold;
   endtask

   // Request held until the edge that sees ready high
   task automatic push(input logic [15:0] w);
      int i;
      @(posedge clk);
      #1;
      tx_valid = 1'b1;
      tx_data = w;
      for (i = 0; tx_ready !== 1'b1; i++) begin
         if (i == 100) timeout;
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1;
      tx_valid = 1'b0;
   endtask

   // Times one word in clock cycles and checks both data directions
   task automatic word(input logic [15:0] tx, rx, input logic pol,
                       input int p, s, r);
      int t, tf, t1, t3, tl, n;
      logic pcs, psck;
      reply = rx;
      tf = -1;
      n = 0;
      t1 = 0;
      t3 = 0;
      tl = 0;
      pcs = cs_n;
      psck = sck;
      for (t = 0; t < 3000; t++) begin
         @(posedge clk);
         #1;
         if (pcs === 1'b1 && cs_n === 1'b0) begin
            tf = t;
            chk_v("idle clock", {15'h0000, pol}, {15'h0000, sck});
            chk_v("busy at start", 16'h0001, {15'h0000, busy});
         end
         if (cs_n === 1'b0 && sck !== psck) begin
            n++;
            if (n == 1) t1 = t;
            if (n == 3) t3 = t;
            tl = t;
         end
         if (pcs === 1'b0 && cs_n === 1'b1 && tf >= 0) break;
         pcs = cs_n;
         psck = sck;
      end
      if (t == 3000) timeout;
      chk_v("done pulse", 16'h0001, {15'h0000, rx_valid});
      chk_v("busy at end", 16'h0000, {15'h0000, busy});
      chk_n("setup gap", s, t1 - tf);
      chk_n("clock period", p, t3 - t1);
      chk_n("toggles", 32, n);
      chk_n("release gap", r, t - tl);
      chk_v("rx word", rx, rx_data);
      chk_v("peer word", tx, got);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic fill_drain;
      int i;
      setup(8'h00, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
      @(posedge clk);
      #1;
      gcr = 32'h0000_0000;
      for (i = 0; i < 8; i++) push(16'h1111 * 16'(i));
      chk_v("full ready", 16'h0000, {15'h0000, tx_ready});
      chk_v("cs when off", 16'h0001, {15'h0000, cs_n});
      chk_v("oe when off", 16'h0000, {15'h0000, sck_oe});
      @(posedge clk);
      #1;
      gcr = 32'h0000_0001;
      for (i = 0; i < 8; i++) begin
         word(16'h1111 * 16'(i), ~(16'h1111 * 16'(i)), 1'b0, 2, 2, 2);
      end
      chk_v("oe when on", 16'h0001, {15'h0000, sck_oe});
      chk_v("drained", 16'h0001, {15'h0000, tx_ready});
   endtask

   // One word in each phase and polarity, timed against the rules
   task automatic four_modes;
      setup(8'h00, 1'b0, 1'b0, 8'h01, 8'h02, 1'b0);
      push(16'ha5c3);
      word(16'ha5c3, 16'h3c5a, 1'b0, 2, 3, 4);
      setup(8'h04, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0);
      push(16'h8001);
      word(16'h8001, 16'h7ffe, 1'b0, 5, 4, 1);
      setup(8'h03, 1'b1, 1'b1, 8'h03, 8'h05, 1'b1);
      push(16'h1234);
      word(16'h1234, 16'hedcb, 1'b1, 4, 8, 6);
      setup(8'h07, 1'b0, 1'b1, 8'h02, 8'h01, 1'b0);
      push(16'hf00f);
      word(16'hf00f, 16'h0ff0, 1'b1, 8, 4, 6);
   endtask

   // Two queued words with the hold option keep select low between
   task automatic held_pair;
      int t, pulses;
      logic [15:0] want;
      setup(8'h01, 1'b1, 1'b1, 8'h00, 8'h00, 1'b1);
      reply = 16'h5a0f;
      push(16'hc3a5);
      push(16'h0ff0);
      pulses = 0;
      for (t = 0; t < 3000 && pulses < 2; t++) begin
         @(posedge clk);
         #1;
         if (rx_valid === 1'b1) begin
            pulses++;
            want = (pulses == 1) ? 16'hc3a5 : 16'h0ff0;
            chk_v("held rx word", 16'h5a0f, rx_data);
            chk_v("held peer word", want, got);
            chk_v("held cs", {15'h0000, pulses == 2}, {15'h0000, cs_n});
         end
      end
      if (pulses < 2) timeout;
   endtask

   // Clearing the controller bit mid-word drops select at once
   task automatic abort_word;
      int i;
      setup(8'h03, 1'b0, 1'b1, 8'h00, 8'h00, 1'b0);
      push(16'h9669);
      for (i = 0; sck !== 1'b0 && i < 100; i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 100) timeout;
      gcr = 32'h0000_0000;
      @(posedge clk);
      #1;
      chk_v("cs after abort", 16'h0001, {15'h0000, cs_n});
      chk_v("clock after abort", 16'h0001, {15'h0000, sck});
      chk_v("pulse after abort", 16'h0000, {15'h0000, rx_valid});
      chk_v("busy after abort", 16'h0000, {15'h0000, busy});
      chk_v("oe after abort", 16'h0000, {15'h0000, sck_oe});
      @(posedge clk);
      #1;
      gcr = 32'h0000_0001;
   endtask

   initial begin
      nrst = 1'b0;
      gcr = 32'h0000_0001;
      fmt = 32'h0000_0000;
      dly = 32'h0000_0000;
      keep = 1'b0;
      tx_valid = 1'b0;
      tx_data = 16'h0000;
      reply = 16'h0000;
      fail_count = 0;
      n_compared = 0;
      repeat (2) @(posedge clk);
      #1;
      nrst = 1'b1;
      chk_v("cs after reset", 16'h0001, {15'h0000, cs_n});
      chk_v("oe after reset", 16'h0000, {15'h0000, sck_oe});
      chk_v("busy after reset", 16'h0000, {15'h0000, busy});
      four_modes();
      held_pair();
      abort_word();
      fill_drain();
      tally_and_finish;
   end
endmodule
